// >>> logic/asx_map.svh
/*
  Opcodes, operand field masks and reset values for the accumulator
  exec datapath. Assumes inclusion by bare name from logic/ files.
*/
`ifndef ASX_MAP_SVH
`define ASX_MAP_SVH
`define ASX_OP_SUBTRACT_WITH_BORROW_REG   8'h9_8
`define ASX_OP_SUBTRACT_WITH_BORROW_DIR   8'h9_5
`define ASX_OP_SUBTRACT_WITH_BORROW_IND   8'h9_6
`define ASX_OP_SUBTRACT_WITH_BORROW_IMM   8'h9_4
`define ASX_OP_SWAP       8'hC_4
`define ASX_OP_XCH_REG    8'hC_8
`define ASX_OP_XCH_DIR    8'hC_5
`define ASX_OP_XCH_IND    8'hC_6
`define ASX_OP_DIGIT_EXCHANGE_IND   8'hD_6
`define ASX_OP_XOR_REG    8'h6_8
`define ASX_OP_XOR_DIR    8'h6_5
`define ASX_OP_XOR_IND    8'h6_6
`define ASX_OP_XOR_IMM    8'h6_4
`define ASX_OP_XOR_DIR_A  8'h6_2
`define ASX_OP_XOR_DIR_I  8'h6_3
`define ASX_MASK_REG      8'hF_8
`define ASX_MASK_IND      8'hF_E
`define ASX_ACC_RESET     8'h0_0
`define ASX_CY_RESET      1'b0
`endif

// >>> logic/asx_pkg.sv
/*
  Types for the accumulator exec datapath.
  Assumes the map header sits beside it.
*/
`default_nettype none
package asx_pkg;
  typedef enum logic [1:0] {
    ASX_IDLE  = 2'b00,
    ASX_XOR2  = 2'b01
  } asx_state_type;

  typedef enum logic [3:0] {
    ASX_NONE    = 4'b0000,
    ASX_SUBTRACT_WITH_BORROW    = 4'b0001,
    ASX_SWAP    = 4'b0010,
    ASX_XCH     = 4'b0011,
    ASX_DIGIT_EXCHANGE    = 4'b0100,
    ASX_XOR_A   = 4'b0101,
    ASX_XOR_D   = 4'b0110,
    ASX_XOR_DI  = 4'b0111
  } asx_op_type;

  typedef enum logic [1:0] {
    ASX_SRC_REG = 2'b00,
    ASX_SRC_DIR = 2'b01,
    ASX_SRC_IND = 2'b10,
    ASX_SRC_IMM = 2'b11
  } asx_src_type;
endpackage
`default_nettype wire

// >>> logic/asx_subtract_with_borrow.sv
/*
  Subtract-with-borrow arithmetic and flag generation.
  Purely combinational; the caller registers the results.
*/
`default_nettype none
module asx_subtract_with_borrow (
  input  wire logic [7:0] i_acc,
  input  wire logic [7:0] i_src,
  input  wire logic       i_carry,
  output logic      [7:0] o_diff,
  output logic            o_carry,
  output logic            o_aux_carry_flag,
  output logic            o_overflow_flag
);
  logic [4:0] lo;
  logic [3:0] mid;
  logic [1:0] hi;
  always_comb begin
    // Split at bits 3 and 6 to expose the internal borrows
    lo  = {1'b0, i_acc[3:0]} - {1'b0, i_src[3:0]} - {4'h0, i_carry};
    mid = {1'b0, i_acc[6:4]} - {1'b0, i_src[6:4]} - {3'h0, lo[4]};
    hi  = {1'b0, i_acc[7]} - {1'b0, i_src[7]} - {1'b0, mid[3]};
    o_diff           = {hi[0], mid[2:0], lo[3:0]};
    o_carry          = hi[1];
    o_aux_carry_flag = lo[4];
    o_overflow_flag  = hi[1] ^ mid[3];
  end
endmodule
`default_nettype wire

// >>> logic/asx_exec.sv
/*
  Exec datapath for subtract-with-borrow, nibble swap, byte and
  digit exchange and exclusive-OR. Assumes the core supplies the
  opcode with its operand bytes, the operand read data (pin levels
  for ports) beside the port latch value, and commits the write-back
  strobes in the same clock.
*/
// Notes on behaviour
// - Accumulator minus source minus carry into accumulator
// - Subtract source: register, direct, indirect, immediate
// - Subtract opcodes decoded, one cycle each
// - Swap exchanges accumulator nibbles, flags kept
// - Exchange swaps accumulator with operand byte
// - Digit exchange swaps low nibbles with RAM
// - Exclusive-OR result to destination, flags kept
// - Six exclusive-OR operand combinations supported
// - Port exclusive-OR into direct reads output latch, not pins
// - Exclusive-OR into accumulator opcodes, one cycle
// - Exclusive-OR into direct: two opcodes, timings
// - Direct exclusive-OR complements masked bits anywhere
// - Carry set on borrow from bit 7
// - Aux carry set on borrow from bit 3
// - Overflow when exactly one of bits 6,7 borrows
`include "asx_map.svh"
`default_nettype none
module asx_exec (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic [7:0]  i_opcode,
  input  wire logic [7:0]  i_byte2,
  input  wire logic [7:0]  i_byte3,
  input  wire logic [1:0]  i_bank,
  input  wire logic [7:0]  i_rd_data,
  input  wire logic [7:0]  i_latch_data,
  input  wire logic        i_is_port,
  output logic             o_busy,
  output logic             o_done,
  output logic [7:0]       o_acc,
  output logic             o_carry,
  output logic             o_aux_carry_flag,
  output logic             o_overflow_flag,
  output logic [7:0]       o_rd_addr,
  output logic             o_rd_is_direct,
  output logic [2:0]       o_working_register_sel,
  output logic             o_pointer_register_sel,
  output logic             o_wr_en,
  output logic [7:0]       o_wr_addr,
  output logic             o_wr_is_direct,
  output logic [7:0]       o_wr_data,
  output asx_pkg::asx_op_type o_last_op
);
  import asx_pkg::*;

  asx_state_type state_q, state_d;
  asx_op_type    op_q, op_d, op;
  asx_src_type   src;
  logic [7:0] acc_q, acc_d, addr_q, addr_d, mask_q, mask_d;
  logic       cy_q, cy_d, ac_q, ac_d, ov_q, ov_d, done_q, done_d;
  logic       wr_q, wr_d, wdir_q, wdir_d;
  logic [7:0] wa_q, wa_d, wd_q, wd_d;
  logic [7:0] src_val, diff;
  logic       s_cy, s_ac, s_ov;

  // Register form: bank in bits 4:3, index in opcode bits 2:0
  function automatic logic [7:0] reg_addr(input logic [1:0] bank,
                                          input logic [2:0] idx);
    reg_addr = {3'b000, bank, idx};
  endfunction

  // Map opcode to operation and source form
  always_comb begin
    op  = ASX_NONE;
    src = ASX_SRC_REG;
    if ((i_opcode & `ASX_MASK_REG) == `ASX_OP_SUBTRACT_WITH_BORROW_REG) begin
      op = ASX_SUBTRACT_WITH_BORROW;
    end else if ((i_opcode & `ASX_MASK_IND) == `ASX_OP_SUBTRACT_WITH_BORROW_IND) begin
      op  = ASX_SUBTRACT_WITH_BORROW;
      src = ASX_SRC_IND;
    end else if (i_opcode == `ASX_OP_SUBTRACT_WITH_BORROW_DIR) begin
      op  = ASX_SUBTRACT_WITH_BORROW;
      src = ASX_SRC_DIR;
    end else if (i_opcode == `ASX_OP_SUBTRACT_WITH_BORROW_IMM) begin
      op  = ASX_SUBTRACT_WITH_BORROW;
      src = ASX_SRC_IMM;
    end else if (i_opcode == `ASX_OP_SWAP) begin
      op = ASX_SWAP;
    end else if ((i_opcode & `ASX_MASK_REG) == `ASX_OP_XCH_REG) begin
      op = ASX_XCH;
    end else if ((i_opcode & `ASX_MASK_IND) == `ASX_OP_XCH_IND) begin
      op  = ASX_XCH;
      src = ASX_SRC_IND;
    end else if (i_opcode == `ASX_OP_XCH_DIR) begin
      op  = ASX_XCH;
      src = ASX_SRC_DIR;
    end else if ((i_opcode & `ASX_MASK_IND) == `ASX_OP_DIGIT_EXCHANGE_IND) begin
      op  = ASX_DIGIT_EXCHANGE;
      src = ASX_SRC_IND;
    end else if ((i_opcode & `ASX_MASK_REG) == `ASX_OP_XOR_REG) begin
      op = ASX_XOR_A;
    end else if ((i_opcode & `ASX_MASK_IND) == `ASX_OP_XOR_IND) begin
      op  = ASX_XOR_A;
      src = ASX_SRC_IND;
    end else if (i_opcode == `ASX_OP_XOR_DIR) begin
      op  = ASX_XOR_A;
      src = ASX_SRC_DIR;
    end else if (i_opcode == `ASX_OP_XOR_IMM) begin
      op  = ASX_XOR_A;
      src = ASX_SRC_IMM;
    end else if (i_opcode == `ASX_OP_XOR_DIR_A) begin
      op  = ASX_XOR_D;
      src = ASX_SRC_DIR;
    end else if (i_opcode == `ASX_OP_XOR_DIR_I) begin
      op  = ASX_XOR_DI;
      src = ASX_SRC_DIR;
    end
  end

  // Operand read address driven straight from the decode
  always_comb begin
    o_working_register_sel = i_opcode[2:0];
    o_pointer_register_sel = i_opcode[0];
    o_rd_is_direct         = (src == ASX_SRC_DIR) && op != ASX_NONE;
    case (src)
      ASX_SRC_REG: o_rd_addr = reg_addr(i_bank, i_opcode[2:0]);
      ASX_SRC_DIR: o_rd_addr = i_byte2;
      // Indirect: core returns pointer target on i_rd_data path
      ASX_SRC_IND: o_rd_addr = reg_addr(i_bank, {2'b00, i_opcode[0]});
      default:     o_rd_addr = 8'h0_0;
    endcase
  end

  // Source byte; only xor into a port reads its latch
  always_comb begin
    if (src == ASX_SRC_IMM) begin
      src_val = i_byte2;
    end else if (src == ASX_SRC_DIR && i_is_port &&
                 (op == ASX_XOR_D || op == ASX_XOR_DI)) begin
      src_val = i_latch_data;
    end else begin
      src_val = i_rd_data;
    end
  end

  asx_subtract_with_borrow u_subtract_with_borrow (
    .i_acc            (acc_q),
    .i_src            (src_val),
    .i_carry          (cy_q),
    .o_diff           (diff),
    .o_carry          (s_cy),
    .o_aux_carry_flag (s_ac),
    .o_overflow_flag  (s_ov)
  );

  always_comb begin
    state_d = state_q;
    op_d    = op_q;
    acc_d   = acc_q;
    cy_d    = cy_q;
    ac_d    = ac_q;
    ov_d    = ov_q;
    addr_d  = addr_q;
    mask_d  = mask_q;
    done_d  = 1'b0;
    wr_d    = 1'b0;
    wdir_d  = 1'b0;
    wa_d    = wa_q;
    wd_d    = wd_q;
    case (state_q)
      ASX_IDLE: begin
        if (i_start && op != ASX_NONE) begin
          op_d = op;
          case (op)
            ASX_SUBTRACT_WITH_BORROW: begin
              acc_d  = diff;
              cy_d   = s_cy;
              ac_d   = s_ac;
              ov_d   = s_ov;
              done_d = 1'b1;
            end
            ASX_SWAP: begin
              acc_d  = {acc_q[3:0], acc_q[7:4]};
              done_d = 1'b1;
            end
            ASX_XCH: begin
              acc_d  = src_val;
              wr_d   = 1'b1;
              wdir_d = (src == ASX_SRC_DIR);
              wa_d   = o_rd_addr;
              wd_d   = acc_q;
              done_d = 1'b1;
            end
            ASX_DIGIT_EXCHANGE: begin
              acc_d  = {acc_q[7:4], src_val[3:0]};
              wr_d   = 1'b1;
              wa_d   = o_rd_addr;
              wd_d   = {src_val[7:4], acc_q[3:0]};
              done_d = 1'b1;
            end
            ASX_XOR_A: begin
              acc_d  = acc_q ^ src_val;
              done_d = 1'b1;
            end
            ASX_XOR_D: begin
              wr_d   = 1'b1;
              wdir_d = 1'b1;
              wa_d   = i_byte2;
              wd_d   = src_val ^ acc_q;
              done_d = 1'b1;
            end
            ASX_XOR_DI: begin
              // First cycle: operand held, write on next clock
              addr_d  = i_byte2;
              mask_d  = i_byte3 ^ src_val;
              state_d = ASX_XOR2;
            end
            default: begin
              op_d = ASX_NONE;
            end
          endcase
        end
      end
      ASX_XOR2: begin
        wr_d    = 1'b1;
        wdir_d  = 1'b1;
        wa_d    = addr_q;
        wd_d    = mask_q;
        done_d  = 1'b1;
        state_d = ASX_IDLE;
      end
      default: state_d = ASX_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ASX_IDLE;
      op_q    <= ASX_NONE;
      acc_q   <= `ASX_ACC_RESET;
      cy_q    <= `ASX_CY_RESET;
      ac_q    <= 1'b0;
      ov_q    <= 1'b0;
      addr_q  <= 8'h0_0;
      mask_q  <= 8'h0_0;
      done_q  <= 1'b0;
      wr_q    <= 1'b0;
      wdir_q  <= 1'b0;
      wa_q    <= 8'h0_0;
      wd_q    <= 8'h0_0;
    end else begin
      state_q <= state_d;
      op_q    <= op_d;
      acc_q   <= acc_d;
      cy_q    <= cy_d;
      ac_q    <= ac_d;
      ov_q    <= ov_d;
      addr_q  <= addr_d;
      mask_q  <= mask_d;
      done_q  <= done_d;
      wr_q    <= wr_d;
      wdir_q  <= wdir_d;
      wa_q    <= wa_d;
      wd_q    <= wd_d;
    end
  end

  always_comb begin
    o_busy           = (state_q != ASX_IDLE);
    o_done           = done_q;
    o_acc            = acc_q;
    o_carry          = cy_q;
    o_aux_carry_flag = ac_q;
    o_overflow_flag  = ov_q;
    o_wr_en          = wr_q;
    o_wr_addr        = wa_q;
    o_wr_is_direct   = wdir_q;
    o_wr_data        = wd_q;
    o_last_op        = op_q;
  end

  a_swap_flags: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_SWAP) |=>
      o_acc == {$past(acc_q[3:0]), $past(acc_q[7:4])} && $stable(cy_q))
    else $error("swap result or flags wrong");
  a_subtract_with_borrow_result: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_SUBTRACT_WITH_BORROW) |=>
      o_acc == 8'($past(acc_q) - $past(src_val) - {7'h0, $past(cy_q)}))
    else $error("subtract result wrong");
  a_subtract_with_borrow_carry: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_SUBTRACT_WITH_BORROW) |=>
      o_carry == ({1'b0, $past(acc_q)} < ({1'b0, $past(src_val)}
                  + {8'h0, $past(cy_q)})))
    else $error("borrow flag wrong");
  a_subtract_with_borrow_aux: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_SUBTRACT_WITH_BORROW) |=>
      o_aux_carry_flag == ({1'b0, $past(acc_q[3:0])} <
        ({1'b0, $past(src_val[3:0])} + {4'h0, $past(cy_q)})))
    else $error("aux borrow wrong");
  a_xch_write: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_XCH) |=>
      o_wr_en && o_wr_data == $past(acc_q) && o_acc == $past(src_val))
    else $error("exchange wrong");
  a_digit_exchange_nib: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_DIGIT_EXCHANGE) |=>
      o_acc[7:4] == $past(acc_q[7:4]) && o_wr_data[3:0] == $past(acc_q[3:0]))
    else $error("digit exchange wrong");
  a_xor_flags: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_XOR_A) |=>
      o_acc == ($past(acc_q) ^ $past(src_val)) && $stable(ov_q))
    else $error("xor into accumulator wrong");
  a_port_latch: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    (i_start && !o_busy && op == ASX_XOR_D && i_is_port) |=>
      o_wr_data == ($past(i_latch_data) ^ $past(acc_q)))
    else $error("port xor did not start from latch");
  sequence s_xor_imm_issue;
    i_start && !o_busy && op == ASX_XOR_DI;
  endsequence
  a_xor_two_cyc: assert property (
    @(posedge i_ref_clk) disable iff (!i_resetn)
    s_xor_imm_issue |=> o_busy && !o_wr_en ##1 o_wr_en && o_done)
    else $error("direct immediate xor timing wrong");
endmodule
`default_nettype wire

// >>> testbench/test_acc_sub_swap_xchg_xor_exec.sv
/*
  Self-checking bench for asx_exec: corner and random opcodes.
  Assumes the logic/ files are compiled first.
*/
`default_nettype none
module test_acc_sub_swap_xchg_xor_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import asx_pkg::*;
  logic        i_ref_clk, i_resetn, i_start, i_is_port;
  logic [7:0]  i_opcode, i_byte2, i_byte3, i_rd_data, i_latch_data;
  logic [1:0]  i_bank;
  logic        o_busy, o_done, o_carry, o_aux_carry_flag;
  logic        o_overflow_flag, o_rd_is_direct, o_pointer_register_sel;
  logic        o_wr_en, o_wr_is_direct;
  logic [7:0]  o_acc, o_rd_addr, o_wr_addr, o_wr_data;
  logic [2:0]  o_working_register_sel;
  asx_op_type  o_last_op;
  int          mismatches, total_checks, idx;
  logic [31:0] seed;
  logic [7:0]  acc_m, op;
  logic        cy_m, ac_m, ov_m;
  logic [7:0]  ops [15] = '{8'h98, 8'h95, 8'h96, 8'h94, 8'hC4, 8'hC8,
    8'hC5, 8'hC6, 8'hD6, 8'h68, 8'h65, 8'h66, 8'h64, 8'h62, 8'h63};

  asx_exec dut_u (.i_ref_clk, .i_resetn, .i_start, .i_opcode, .i_byte2,
    .i_byte3, .i_bank, .i_rd_data, .i_latch_data, .i_is_port, .o_busy,
    .o_done, .o_acc, .o_carry, .o_aux_carry_flag, .o_overflow_flag,
    .o_rd_addr, .o_rd_is_direct, .o_working_register_sel,
    .o_pointer_register_sel, .o_wr_en, .o_wr_addr, .o_wr_is_direct,
    .o_wr_data, .o_last_op);

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] rnd8();
    repeat (8) seed = lfsr(seed);
    return seed[7:0];
  endfunction

  // Returns {borrow7, borrow3, overflow, difference}
  function automatic logic [10:0] subtract_with_borrow_f(input logic [7:0] a, s,
                                         input logic c);
    logic [8:0] d;
    logic       h;
    d = {1'b0, a} - {1'b0, s} - {8'h00, c};
    h = ({1'b0, a[3:0]} < ({1'b0, s[3:0]} + {4'h0, c}));
    return {d[8], h, (a[7] ^ s[7]) & (a[7] ^ d[7]), d[7:0]};
  endfunction

  task automatic chk8(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (mismatches == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic do_op(input logic [7:0] o, b2, b3, rd, lt,
                       input logic prt, input logic [1:0] bk);
    logic [7:0] src, wd, a0;
    logic       we, reg_f, ind_f, dir_f;
    asx_op_type k;
    reg_f = o[3];
    ind_f = (o[3:1] == 3'b011);
    dir_f = (o[3:0] == 4'h5) || (o[7:1] == 7'b0110001);
    src = ((o[7:1] == 7'b0110001) && prt) ? lt :
          ((o == 8'h94 || o == 8'h64) ? b2 : rd);
    a0 = acc_m;
    we = 1'b0;
    wd = 8'h00;
    case (o[7:4])
      4'h9: begin
        {cy_m, ac_m, ov_m, acc_m} = subtract_with_borrow_f(a0, src, cy_m);
        k = ASX_SUBTRACT_WITH_BORROW;
      end
      4'hC: begin
        k = (o == 8'hC4) ? ASX_SWAP : ASX_XCH;
        acc_m = (o == 8'hC4) ? {a0[3:0], a0[7:4]} : src;
        we = (o != 8'hC4);
        wd = a0;
      end
      4'hD: begin
        acc_m = {a0[7:4], src[3:0]};
        we = 1'b1;
        wd = {src[7:4], a0[3:0]};
        k = ASX_DIGIT_EXCHANGE;
      end
      default: begin
        we = (o[3:1] == 3'b001);
        wd = (o[0] ? b3 : a0) ^ src;
        k = !we ? ASX_XOR_A : (o[0] ? ASX_XOR_DI : ASX_XOR_D);
        if (!we) acc_m = a0 ^ src;
      end
    endcase
    @(posedge i_ref_clk);
    i_start <= 1'b1;
    i_opcode <= o;
    i_byte2 <= b2;
    i_byte3 <= b3;
    i_rd_data <= rd;
    i_latch_data <= lt;
    i_is_port <= prt;
    i_bank <= bk;
    @(negedge i_ref_clk);
    chk1(o_busy, 1'b0);
    chk1(o_rd_is_direct, dir_f);
    if (reg_f) begin
      chk8(o_rd_addr, {3'b000, bk, o[2:0]});
      chk8({5'h00, o_working_register_sel}, {5'h00, o[2:0]});
    end
    if (ind_f) begin
      chk8(o_rd_addr, {3'b000, bk, 2'b00, o[0]});
      chk1(o_pointer_register_sel, o[0]);
    end
    if (dir_f) chk8(o_rd_addr, b2);
    @(posedge i_ref_clk);
    if (o == 8'h63) begin
      // Swap offered while busy must be dropped
      i_opcode <= 8'hC4;
      @(negedge i_ref_clk);
      chk1(o_busy, 1'b1);
      chk1(o_done, 1'b0);
      @(posedge i_ref_clk);
    end
    i_start <= 1'b0;
    @(negedge i_ref_clk);
    chk1(o_done, 1'b1);
    chk1(o_wr_en, we);
    if (we) chk8(o_wr_data, wd);
    if (we && !ind_f)
      chk8(o_wr_addr, reg_f ? {3'b000, bk, o[2:0]} : b2);
    if (we) chk1(o_wr_is_direct, dir_f);
    chk8(o_acc, acc_m);
    chk1(o_carry, cy_m);
    chk1(o_aux_carry_flag, ac_m);
    chk1(o_overflow_flag, ov_m);
    chk8({4'h0, o_last_op}, {4'h0, k});
  endtask

  task automatic rnd_ops(input int n);
    repeat (n) begin
      idx = int'(rnd8()) % 15;
      op = ops[idx];
      if (op[3]) op[2:0] = 3'(rnd8());
      if (op[3:1] == 3'b011) op[0] = 1'(rnd8());
      do_op(op, rnd8(), rnd8(), rnd8(), rnd8(), rnd8() > 8'h7F, 2'(rnd8()));
    end
  endtask

  initial begin
    {i_resetn, i_start, i_is_port, i_bank} = '0;
    {i_opcode, i_byte2, i_byte3, i_rd_data, i_latch_data} = '0;
    {acc_m, cy_m, ac_m, ov_m} = '0;
    mismatches = 0;
    total_checks = 0;
    seed = 32'h0000_8cb2;
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    // Borrow chain ending in the overflow-only case
    do_op(8'hC5, 8'h30, 8'h00, 8'h00, 8'h00, 1'b0, 2'b01);
    do_op(8'h94, 8'h01, 8'h00, 8'h00, 8'h00, 1'b0, 2'b00);
    do_op(8'hCA, 8'h00, 8'h00, 8'hC9, 8'h00, 1'b0, 2'b10);
    do_op(8'h9A, 8'h00, 8'h00, 8'h54, 8'h00, 1'b0, 2'b00);
    do_op(8'hC4, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 2'b00);
    do_op(8'hD7, 8'h00, 8'h00, 8'h75, 8'h00, 1'b0, 2'b11);
    // Port writes must start from the latch, not the pins
    do_op(8'h62, 8'h90, 8'h00, 8'h11, 8'h5A, 1'b1, 2'b00);
    do_op(8'h63, 8'h90, 8'h31, 8'hEE, 8'h5A, 1'b1, 2'b00);
    // Port read into the accumulator takes the pins
    do_op(8'h65, 8'h90, 8'h00, 8'h3C, 8'h5A, 1'b1, 2'b00);
    @(posedge i_ref_clk);
    i_start <= 1'b1;
    i_opcode <= 8'hA5;
    @(posedge i_ref_clk);
    i_start <= 1'b0;
    @(negedge i_ref_clk);
    chk1(o_done, 1'b0);
    chk8(o_acc, acc_m);
    rnd_ops(600);
    @(posedge i_ref_clk);
    i_resetn <= 1'b0;
    repeat (2) @(negedge i_ref_clk);
    chk8(o_acc, 8'h00);
    chk1(o_carry, 1'b0);
    chk1(o_aux_carry_flag, 1'b0);
    chk1(o_overflow_flag, 1'b0);
    chk1(o_wr_en, 1'b0);
    chk1(o_done, 1'b0);
    chk1(o_busy, 1'b0);
    {acc_m, cy_m, ac_m, ov_m} = '0;
    @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    rnd_ops(100);
    results();
  end
endmodule
`default_nettype wire
